// >>> bench/gfc_src_model.sv
// Behavioural source of the small external signal on the counter pin.
// Assumes the bench calls burst; the line rests low between bursts.
`timescale 1ns/10ps
module gfc_src_model (
  output logic pin
);
  initial pin = 1'b0;

  // A 260 ns period stays well inside what a 10 MHz sampler can resolve.
  task automatic burst(input int n);
    repeat (n) begin
      #130 pin = 1'b1;
      #130 pin = 1'b0;
    end
  endtask : burst
endmodule : gfc_src_model

// >>> bench/gfc_top_tb.sv
// Self-checking bench of the gated counter, driven through APB.
// Assumes the constants header on the include path and short gate counts.
`timescale 1ns/10ps
`include "gfc_params.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module gfc_top_tb;
  import gfc_pkg::*;
  localparam int G[4] = '{40, 80, 160, 320};
  logic        CLK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00, PORT_ACTIVITY = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        PREADY, PSLVERR, pin, COUNTER_SELECT, WAKE_REQ, MEM_WE, err;
  logic [8:0]  MEM_ADDR, mem_adr;
  logic [19:0] MEM_WDATA, mem_val;
  int          miscompares = 0, samples_checked = 0, mem_hits = 0;

  always #50 CLK = ~CLK;
  gfc_src_model src_u (.pin(pin));
  gfc_top #(.GATE0(G[0]), .GATE1(G[1]), .GATE2(G[2]), .GATE3(G[3])) dut_u (
    .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PORT_ONE_LINE_ZERO(pin), .PORT_ACTIVITY(PORT_ACTIVITY), .COUNTER_SELECT(COUNTER_SELECT),
    .WAKE_REQ(WAKE_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA));

  always @(posedge CLK) begin
    if (MEM_WE === 1'b1) begin
      mem_hits <= mem_hits + 1;
      mem_val  <= MEM_WDATA;
      mem_adr  <= MEM_ADDR;
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait for a slave that never answers.
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd      = PRDATA;
    err     = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  function automatic logic [31:0] ctrl(input int g, input int src, input bit man);
    return (32'h1 << `GFC_CTRL_START) | (32'(g) << `GFC_CTRL_GSEL) |
      (32'h1 << `GFC_CTRL_CTSEL) | (32'(src) << `GFC_CTRL_CLKSRC) |
      (32'(man) << `GFC_CTRL_MANUAL);
  endfunction : ctrl

  // Polls DONE, then clears it so the next wait sees a fresh DONE.
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, `GFC_OFF_STATUS, 32'h0);
      n++;
    end while (rd[`GFC_ST_DONE] !== 1'b1 && n < 200);
    `CHK(rd[`GFC_ST_DONE], 1'b1)
    apb(1'b1, `GFC_OFF_STATUS, 32'h1 << `GFC_ST_DONE);
  endtask : wait_done

  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #3_000_000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    `CHK(COUNTER_SELECT, 1'b0)
    apb(1'b0, `GFC_OFF_CTRL, 32'h0);
    `CHK(rd[7:0], `GFC_CTRL_RST)
    apb(1'b0, 8'h3c, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, `GFC_OFF_MADDR, 32'h1a5);
    // Pulse counting with an automatic gate.
    apb(1'b1, `GFC_OFF_CTRL, ctrl(0, 0, 1'b0));
    // The select output follows the control register one clock later.
    repeat (2) @(posedge CLK);
    `CHK(COUNTER_SELECT, 1'b1)
    src_u.burst(3);
    wait_done();
    apb(1'b0, `GFC_OFF_COUNT, 32'h0);
    `CHK(rd[19:0], 20'h3)
    `CHK(mem_val, 20'h3)
    `CHK(mem_adr, 9'h1a5)
    `CHK(mem_hits, 1)
    src_u.burst(2);
    apb(1'b0, `GFC_OFF_COUNT, 32'h0);
    `CHK(rd[19:0], 20'h3)
    // Timer mode: every gate length is counted in clocks.
    for (int s = 2; s < 4; s++) begin
      for (int g = 0; g < 4; g++) begin
        apb(1'b1, `GFC_OFF_CTRL, ctrl(g, s, 1'b0));
        wait_done();
        apb(1'b0, `GFC_OFF_COUNT, 32'h0);
        `CHK(rd[19:0], 20'(G[g]))
        apb(1'b0, `GFC_OFF_STATUS, 32'h0);
        `CHK(rd[`GFC_ST_TIMER], 1'b1)
      end
    end
    // A new gate without pulses must start from zero; the 75 kHz source is no timer.
    apb(1'b1, `GFC_OFF_CTRL, ctrl(0, 1, 1'b0));
    wait_done();
    `CHK(mem_val, 20'h0)
    apb(1'b0, `GFC_OFF_STATUS, 32'h0);
    `CHK(rd[`GFC_ST_TIMER], 1'b0)
    // Manual gate: software opens and closes it.
    apb(1'b1, `GFC_OFF_CTRL, ctrl(0, 0, 1'b1));
    repeat (60) @(posedge CLK);
    apb(1'b0, `GFC_OFF_STATUS, 32'h0);
    `CHK(rd[`GFC_ST_BUSY], 1'b1)
    src_u.burst(2);
    repeat (5) @(posedge CLK);
    apb(1'b1, `GFC_OFF_CTRL, (32'h1 << `GFC_CTRL_STOP) | (32'h1 << `GFC_CTRL_MANUAL));
    wait_done();
    `CHK(mem_val, 20'h2)
    // Wake enable is per port.
    apb(1'b1, `GFC_OFF_WAKE, 32'h04);
    PORT_ACTIVITY <= 8'h02;
    repeat (6) @(posedge CLK);
    `CHK(WAKE_REQ, 1'b0)
    PORT_ACTIVITY <= 8'h04;
    repeat (6) @(posedge CLK);
    `CHK(WAKE_REQ, 1'b1)
    conclude();
  end
endmodule : gfc_top_tb

// >>> logic/gfc_params.svh
// Constants of the gated frequency counter: offsets, fields, resets, times.
// Assumes a 10 MHz system clock; included by the package, gfc_top and the bench.
`ifndef GFC_PARAMS_SVH
`define GFC_PARAMS_SVH
`define GFC_OFF_CTRL    8'h00
`define GFC_OFF_STATUS  8'h04
`define GFC_OFF_COUNT   8'h08
`define GFC_OFF_MADDR   8'h0c
`define GFC_OFF_WAKE    8'h10
`define GFC_OFF_PORT    8'h14
`define GFC_CTRL_START  0
`define GFC_CTRL_STOP   1
`define GFC_CTRL_MANUAL 2
`define GFC_CTRL_GSEL   3
`define GFC_CTRL_CTSEL  5
`define GFC_CTRL_CLKSRC 6
`define GFC_ST_BUSY     0
`define GFC_ST_DONE     1
`define GFC_ST_TIMER    2
`define GFC_ST_OVF      3
`define GFC_CTRL_RST    8'h00
`define GFC_WAKE_RST    8'h00
`define GFC_MADDR_RST   9'h000
`define GFC_CLK_NS      100
`define GFC_GATE0_US    1000
`define GFC_GATE1_US    4000
`define GFC_GATE2_US    16000
`define GFC_GATE3_US    64000
`define GFC_US2CYC(us)  (((us) * 1000) / `GFC_CLK_NS)
`endif

// >>> logic/gfc_pin_sync.sv
// Two-flop synchroniser and rising edge detector for the counter pin.
// Assumes the pin is asynchronous to CLK and slower than half of it.
`timescale 1ns/10ps
module gfc_pin_sync (
  input  wire logic CLK,
  input  wire logic ARST_N,
  input  wire logic pin,
  gfc_sig_if.src    sig
);
  logic meta;
  logic stable;
  logic prev;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= pin;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign sig.level = stable;
  assign sig.rise  = stable & ~prev;
endmodule : gfc_pin_sync

// >>> logic/gfc_pkg.sv
// Types of the gated frequency counter.
// Assumes the constants header is on the include path.
`include "gfc_params.svh"
package gfc_pkg;
  typedef enum logic {GFC_IDLE, GFC_GATE} gfc_state_t;
  typedef enum logic [1:0] {GFC_CLK_FAST, GFC_CLK_75K, GFC_CLK_32K, GFC_CLK_RC} gfc_clksrc_t;
endpackage : gfc_pkg

// >>> logic/gfc_sig_if.sv
// Carrier between the pin conditioner and the counter core.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface gfc_sig_if;
  logic rise;
  logic level;
  modport src (output rise, output level);
  modport dst (input rise, input level);
endinterface : gfc_sig_if

// >>> logic/gfc_top.sv
// Gated 20-bit frequency counter with an APB register slave.
// Assumes a 10 MHz CLK; port pins arrive asynchronously.
`timescale 1ns/10ps
`include "gfc_params.svh"
module gfc_top
  import gfc_pkg::*;
#(
  parameter int CW      = 20,
  parameter int NPORT   = 8,
  parameter int GATE0   = `GFC_US2CYC(`GFC_GATE0_US),
  parameter int GATE1   = `GFC_US2CYC(`GFC_GATE1_US),
  parameter int GATE2   = `GFC_US2CYC(`GFC_GATE2_US),
  parameter int GATE3   = `GFC_US2CYC(`GFC_GATE3_US)
) (
  input  wire logic             CLK,
  input  wire logic             ARST_N,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic             PORT_ONE_LINE_ZERO,
  input  wire logic [NPORT-1:0] PORT_ACTIVITY,
  output logic                  COUNTER_SELECT,
  output logic                  WAKE_REQ,
  output logic                  MEM_WE,
  output logic      [8:0]       MEM_ADDR,
  output logic      [CW-1:0]    MEM_WDATA
);
  gfc_sig_if sig ();
  gfc_state_t       state;
  logic [7:0]       ctrl;
  logic [8:0]       maddr;
  logic [NPORT-1:0] wake_en;
  logic [NPORT-1:0] act_meta;
  logic [NPORT-1:0] act_sync;
  logic [CW-1:0]    count;
  logic [19:0]      gate_left;
  logic             done;
  logic             ovf;
  logic             wr;
  logic             start;
  logic             stop;
  logic             timer_mode;
  logic             tick;
  logic             auto_end;
  logic             gate_end;

  gfc_pin_sync u_sync (
    .CLK    (CLK),
    .ARST_N (ARST_N),
    .pin    (PORT_ONE_LINE_ZERO),
    .sig    (sig)
  );

  function automatic logic [19:0] gate_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: gate_cycles = 20'(GATE0);
      2'h1: gate_cycles = 20'(GATE1);
      2'h2: gate_cycles = 20'(GATE2);
      2'h3: gate_cycles = 20'(GATE3);
    endcase
  endfunction : gate_cycles

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // Writes land only at the completing access edge, as the bus demands.
  assign wr    = PSEL & PENABLE & PREADY & PWRITE;
  assign start = wr & hit(PADDR, `GFC_OFF_CTRL) & PWDATA[`GFC_CTRL_START];
  assign stop  = wr & hit(PADDR, `GFC_OFF_CTRL) & PWDATA[`GFC_CTRL_STOP];
  assign timer_mode = (ctrl[`GFC_CTRL_CLKSRC +: 2] == GFC_CLK_32K) |
                      (ctrl[`GFC_CTRL_CLKSRC +: 2] == GFC_CLK_RC);
  // Timer mode counts system clocks; pin edges above 5 MHz are lost by sampling.
  assign tick     = timer_mode ? 1'b1 : (sig.rise & ctrl[`GFC_CTRL_CTSEL]);
  assign auto_end = ~ctrl[`GFC_CTRL_MANUAL] & (gate_left == 20'h00001);
  assign gate_end = (state == GFC_GATE) & (auto_end | (ctrl[`GFC_CTRL_MANUAL] & stop));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl    <= `GFC_CTRL_RST;
      maddr   <= `GFC_MADDR_RST;
      wake_en <= NPORT'(`GFC_WAKE_RST);
    end else if (wr) begin
      if (hit(PADDR, `GFC_OFF_CTRL)) begin
        ctrl <= {PWDATA[7:2], 2'b00};
      end
      if (hit(PADDR, `GFC_OFF_MADDR)) begin
        maddr <= PWDATA[8:0];
      end
      if (hit(PADDR, `GFC_OFF_WAKE)) begin
        wake_en <= PWDATA[NPORT-1:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state     <= GFC_IDLE;
      gate_left <= 20'h00000;
    end else begin
      unique case (state)
        GFC_IDLE: begin
          if (start) begin
            state     <= GFC_GATE;
            gate_left <= gate_cycles(PWDATA[`GFC_CTRL_GSEL +: 2]);
          end
        end
        GFC_GATE: begin
          if (gate_end) begin
            state <= GFC_IDLE;
          end else if (gate_left != 20'h00000) begin
            gate_left <= gate_left - 20'h00001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= '0;
      ovf   <= 1'b0;
    end else if (state == GFC_IDLE && start) begin
      count <= '0;
      ovf   <= 1'b0;
    end else if (state == GFC_GATE && tick) begin
      count <= count + CW'(1);
      if (&count) begin
        ovf <= 1'b1;
      end
    end
  end

  // A closing gate sets done even if software clears it in the same cycle.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      done <= 1'b0;
    end else if (gate_end) begin
      done <= 1'b1;
    end else if (wr && hit(PADDR, `GFC_OFF_STATUS) && PWDATA[`GFC_ST_DONE]) begin
      done <= 1'b0;
    end
  end

  // The final count is stored whole, one cycle after the gate closes.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_WE    <= 1'b0;
      MEM_ADDR  <= 9'h000;
      MEM_WDATA <= '0;
    end else begin
      MEM_WE <= gate_end;
      if (gate_end) begin
        MEM_ADDR  <= maddr;
        MEM_WDATA <= (state == GFC_GATE && tick) ? count + CW'(1) : count;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      act_meta       <= '0;
      act_sync       <= '0;
      WAKE_REQ       <= 1'b0;
      COUNTER_SELECT <= 1'b0;
    end else begin
      act_meta       <= PORT_ACTIVITY;
      act_sync       <= act_meta;
      WAKE_REQ       <= |(act_sync & wake_en);
      COUNTER_SELECT <= ctrl[`GFC_CTRL_CTSEL];
    end
  end

  // Zero-wait slave: answer is registered in setup and shown in the access cycle.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
      if (PSEL && !PENABLE) begin
        unique case (PADDR)
          `GFC_OFF_CTRL:   PRDATA <= {24'h000000, ctrl};
          `GFC_OFF_STATUS: PRDATA <= {28'h0000000, ovf, timer_mode, done, state == GFC_GATE};
          `GFC_OFF_COUNT:  PRDATA <= 32'(count);
          `GFC_OFF_MADDR:  PRDATA <= {23'h000000, maddr};
          `GFC_OFF_WAKE:   PRDATA <= 32'(wake_en);
          `GFC_OFF_PORT:   PRDATA <= {31'h00000000, sig.level};
          default:         PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_count_grows: assert property ((state == GFC_GATE) && tick && !gate_end && !(&count)
    |=> count == $past(count) + CW'(1)) else $error("count missed an edge");
  a_mem_store: assert property (gate_end |=> MEM_WE && MEM_ADDR == $past(maddr))
    else $error("count not stored at gate close");
  a_auto_len: assert property ((state == GFC_IDLE) && start && !PWDATA[`GFC_CTRL_MANUAL]
    && PWDATA[`GFC_CTRL_GSEL +: 2] == 2'h0 |=> (state == GFC_GATE) [*2])
    else $error("auto gate closed early");
  a_manual_stop: assert property ((state == GFC_GATE) && ctrl[`GFC_CTRL_MANUAL] && stop
    |=> state == GFC_IDLE && MEM_WE) else $error("manual stop ignored");
  a_manual_hold: assert property ((state == GFC_GATE) && ctrl[`GFC_CTRL_MANUAL] && !stop
    |=> state == GFC_GATE) else $error("manual gate closed by itself");
  a_timer_mode: assert property (timer_mode && (state == GFC_GATE) && !gate_end
    && !(&count) |=> count != $past(count)) else $error("timer did not advance");
  a_pin_gated: assert property (!timer_mode && !ctrl[`GFC_CTRL_CTSEL]
    |=> $stable(count) || $past(start)) else $error("deselected pin counted");
  a_sel_follow: assert property (wr && hit(PADDR, `GFC_OFF_CTRL)
    |=> ##1 COUNTER_SELECT == $past(PWDATA[`GFC_CTRL_CTSEL], 2))
    else $error("counter select lagging");
  a_wake_gate: assert property (act_sync == '0 |=> !WAKE_REQ)
    else $error("wake without activity");
  a_hold_count: assert property ((state == GFC_IDLE) && !start |=> $stable(count))
    else $error("count moved while idle");
  a_start_clear: assert property ((state == GFC_IDLE) && start |=> count == '0)
    else $error("count not cleared at start");

  c_auto_run: cover property ((state == GFC_GATE) && auto_end ##1 MEM_WE);
  c_manual_run: cover property ((state == GFC_GATE) && ctrl[`GFC_CTRL_MANUAL] && stop);
  c_timer_run: cover property (timer_mode && (state == GFC_GATE) ##1 count != '0);
  c_bad_addr: cover property (PSLVERR && PREADY);
endmodule : gfc_top
